// [common/sia_pkg.sv]
// Purpose: shared types and constants for the streaming adapter chain
// Assumes: one clock, 128-bit source stream, 32-bit sink lanes
// Notes: beat carriers are packed structs
package sia_pkg;
   localparam int IN_DATA_W    = 128;
   localparam int OUT_DATA_W   = 32;
   localparam int LANES        = IN_DATA_W / OUT_DATA_W;
   localparam int LANE_IDX_W   = 2;
   localparam int IN_CH_W      = 4;
   localparam int OUT_CH_W     = 6;
   localparam int IN_ERR_W     = 3;
   localparam int OUT_ERR_W    = 3;
   localparam int FIFO_DEPTH   = 4;
   // source error bit i maps to sink bit ERR_MAP[i]; -1 means unsupported
   localparam int ERR_MAP [IN_ERR_W] = '{0, 1, -1};
   // sink channel numbers at or above this are unreachable
   localparam logic [IN_CH_W-1:0] SINK_CH_LIMIT = 4'ha;
   localparam logic [LANE_IDX_W-1:0] LANE_LAST  = 2'h3;
   localparam logic [LANE_IDX_W-1:0] LANE_FIRST = 2'h0;

   typedef struct packed {
      logic [IN_DATA_W-1:0] data;
      logic [IN_CH_W-1:0]   channel;
      logic [IN_ERR_W-1:0]  error;
      logic                 sop;
      logic                 eop;
   } sia_in_beat_t;

   typedef struct packed {
      logic [OUT_DATA_W-1:0] data;
      logic [OUT_CH_W-1:0]   channel;
      logic [OUT_ERR_W-1:0]  error;
      logic                  sop;
      logic                  eop;
   } sia_out_beat_t;

   localparam int IN_BEAT_W = $bits(sia_in_beat_t);
endpackage : sia_pkg

// [hdl/sia_adapter.sv]
// Purpose: channel, error, FIFO timing and data format adaptation
// Assumes: source side may lack ready; sink side honours back pressure
// Notes: all outputs registered; sink inputs used combinationally
`timescale 1ns/100ps
`default_nettype none

module sia_fifo
   import sia_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [AW:0]      cnt_ff, nxt_cnt;
   logic             push, pop;

   always_comb begin
      push     = in_valid && (cnt_ff != (AW+1)'(DEPTH));
      pop      = (cnt_ff != '0) && out_ready;
      nxt_wr   = push ? wr_ff + AW'(1) : wr_ff;
      nxt_rd   = pop ? rd_ff + AW'(1) : rd_ff;
      nxt_cnt  = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      in_ready = (cnt_ff != (AW+1)'(DEPTH));
      out_valid = (cnt_ff != '0);
      out_data = mem_ff[rd_ff];
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else if (clk_en) begin
         wr_ff  <= nxt_wr;  // in-order write pointer
         rd_ff  <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clk_en && push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end
endmodule : sia_fifo

module sia_adapter
   import sia_pkg::*;
(
   // clock and reset
   input  wire logic                ref_clk,
   input  wire logic                reset_n,
   input  wire logic                clk_en,
   // source side
   input  wire logic                src_valid,
   input  wire sia_in_beat_t        src_beat,
   output logic                     src_ready,
   // sink side
   output logic                     snk_valid,
   output sia_out_beat_t            snk_beat,
   input  wire logic                snk_ready,
   // status
   output logic                     err_unsup_ff,
   output logic                     drop_ff,
   output logic                     overrun_ff
);
   typedef enum logic [0:0] {ST_IDLE, ST_SEND} sia_state_t;

   sia_in_beat_t  adj_beat, f_beat, cur_ff, nxt_cur;
   logic          keep, f_valid, f_ready, fifo_in_ready;
   sia_state_t    st_ff, nxt_st;
   logic [LANE_IDX_W-1:0] lane_ff, nxt_lane;
   sia_out_beat_t out_ff, nxt_out;
   logic          vld_ff, nxt_vld;
   logic          nxt_err, nxt_drop, nxt_overrun;

   // map source error vector onto sink positions
   function automatic logic [OUT_ERR_W-1:0] map_err(
      input logic [IN_ERR_W-1:0] e);
      logic [OUT_ERR_W-1:0] r;
      r = '0;  // unsourced sink bits stay zero
      for (int i = 0; i < IN_ERR_W; i++) begin
         if (ERR_MAP[i] >= 0) begin
            r[ERR_MAP[i]] = e[i];
         end
      end
      return r;
   endfunction : map_err

   function automatic logic unsup_err(input logic [IN_ERR_W-1:0] e);
      logic r;
      r = 1'b0;
      for (int i = 0; i < IN_ERR_W; i++) begin
         if (ERR_MAP[i] < 0) begin
            r = r | e[i];
         end
      end
      return r;
   endfunction : unsup_err

   // channel range filter ahead of the FIFO
   always_comb begin
      adj_beat = src_beat;
      keep     = src_beat.channel < SINK_CH_LIMIT;
   end

   sia_fifo #(
      .WIDTH (IN_BEAT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .clk_en    (clk_en),
      .in_valid  (src_valid && keep),  // buffered timing path
      .in_ready  (fifo_in_ready),
      .in_data   (adj_beat),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_beat)
   );

   // width converter: one wide beat becomes LANES narrow beats
   always_comb begin
      nxt_st   = st_ff;
      nxt_lane = lane_ff;
      nxt_cur  = cur_ff;
      nxt_out  = out_ff;
      nxt_vld  = vld_ff;
      f_ready  = 1'b0;
      if (vld_ff && snk_ready) begin
         nxt_vld = 1'b0;  // sink input used directly
      end
      if (!nxt_vld) begin
         unique case (st_ff)
            ST_IDLE: begin
               if (f_valid) begin
                  f_ready  = 1'b1;
                  nxt_cur  = f_beat;
                  nxt_lane = LANE_FIRST;
                  nxt_st   = ST_SEND;
               end
            end
            ST_SEND: begin
               // most significant lane first
               nxt_out.data = cur_ff.data[IN_DATA_W-1-
                  int'(lane_ff)*OUT_DATA_W -: OUT_DATA_W];
               nxt_out.channel = OUT_CH_W'(cur_ff.channel);
               nxt_out.error   = map_err(cur_ff.error);
               nxt_out.sop = cur_ff.sop && (lane_ff == LANE_FIRST);
               nxt_out.eop = cur_ff.eop && (lane_ff == LANE_LAST);
               nxt_vld     = 1'b1;
               nxt_lane    = lane_ff + LANE_IDX_W'(1);
               if (lane_ff == LANE_LAST) begin
                  nxt_st = ST_IDLE;
               end
            end
         endcase
      end
   end

   // sticky status
   always_comb begin
      nxt_err     = err_unsup_ff | (src_valid && unsup_err(src_beat.error));
      nxt_drop    = drop_ff | (src_valid && !keep);
      nxt_overrun = overrun_ff | (src_valid && keep && !fifo_in_ready);
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff        <= ST_IDLE;
         lane_ff      <= '0;
         cur_ff       <= '0;
         out_ff       <= '0;
         vld_ff       <= 1'b0;
         err_unsup_ff <= 1'b0;
         drop_ff      <= 1'b0;
         overrun_ff   <= 1'b0;
         src_ready    <= 1'b0;
      end else if (clk_en) begin  // all transfers on rising edge
         st_ff        <= nxt_st;
         lane_ff      <= nxt_lane;
         cur_ff       <= nxt_cur;
         out_ff       <= nxt_out;   // registered sink outputs
         vld_ff       <= nxt_vld;
         err_unsup_ff <= nxt_err;
         drop_ff      <= nxt_drop;
         overrun_ff   <= nxt_overrun;
         // ready advertised only if a slot is still free after this cycle's push and pop
         src_ready    <= fifo_in_ready && !(f_valid && !f_ready &&
                         (src_valid && keep)) ;
      end
   end

   // single point-to-point link out
   assign snk_valid = vld_ff;
   assign snk_beat  = out_ff;
endmodule : sia_adapter

`default_nettype wire

// [verif/sia_adapter_asserts.sv]
// Purpose: port checker for sia_adapter
// Assumes: one clock, async active-low reset
// Notes: bound to every sia_adapter
`timescale 1ns/100ps
`default_nettype none
module sia_adapter_asserts
   import sia_pkg::*;
(
   // clock and reset
   input wire logic          ref_clk,
   input wire logic          reset_n,
   input wire logic          clk_en,
   // source side
   input wire logic          src_valid,
   input wire sia_in_beat_t  src_beat,
   input wire logic          src_ready,
   // sink side
   input wire logic          snk_valid,
   input wire sia_out_beat_t snk_beat,
   input wire logic          snk_ready,
   // status
   input wire logic          err_unsup_ff,
   input wire logic          drop_ff,
   input wire logic          overrun_ff
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   wire logic in_ok = clk_en && src_valid;
   wire logic keep = in_ok && src_beat.channel < SINK_CH_LIMIT;
   hold_valid_a: assert property (
      snk_valid && !snk_ready |=> snk_valid)
      else $error("sink valid withdrawn under stall");
   hold_beat_a: assert property (
      snk_valid && !snk_ready |=> $stable(snk_beat))
      else $error("sink beat changed under stall");
   ch_high_zero_a: assert property (
      snk_valid |-> snk_beat.channel[5:4] == 2'h0)
      else $error("sink channel high bits set");
   ch_range_a: assert property (
      snk_valid |-> snk_beat.channel < 6'h0a)
      else $error("out of range channel forwarded");
   err_tie_a: assert property (
      snk_valid |-> !snk_beat.error[2])
      else $error("unsourced sink error bit set");
   beat_latency_a: assert property (
      keep && src_ready && !snk_valid |-> ##[1:3] snk_valid)
      else $error("beat not presented in time");
   unsup_flag_a: assert property (
      in_ok && src_beat.error[2] |=> err_unsup_ff)
      else $error("unsupported error not flagged");
   drop_flag_a: assert property (
      in_ok && !keep |=> drop_ff)
      else $error("dropped beat not flagged");
   flags_sticky_a: assert property (
      !$fell(err_unsup_ff) && !$fell(drop_ff))
      else $error("status flag cleared");
   cover property (keep);
   cover property (in_ok && !keep);
   cover property (snk_valid && snk_ready && snk_beat.eop);
endmodule : sia_adapter_asserts
bind sia_adapter sia_adapter_asserts u_chk (.ref_clk(ref_clk),
   .reset_n(reset_n), .clk_en(clk_en), .src_valid(src_valid),
   .src_beat(src_beat), .src_ready(src_ready), .snk_valid(snk_valid),
   .snk_beat(snk_beat), .snk_ready(snk_ready),
   .err_unsup_ff(err_unsup_ff), .drop_ff(drop_ff), .overrun_ff(overrun_ff));
`default_nettype wire

// [verif/sia_sink_model.sv]
// Purpose: far-side sink applying back pressure
// Assumes: stall request comes from the bench
// Notes: ready changes just after the rising edge
`timescale 1ns/100ps
`default_nettype none
module sia_sink_model (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic reset_n,
   // control
   input  wire logic stall,
   // sink side
   output logic      snk_ready
);
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) snk_ready <= 1'b0;
      else snk_ready <= !stall;
   end
endmodule : sia_sink_model
`default_nettype wire

// [verif/tb_top.sv]
// Purpose: random stream through sia_adapter against a lane model
// Assumes: source offers beats only while src_ready is high
// Notes: sink stalls at random
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import sia_pkg::*;
   logic ref_clk = 0, reset_n = 0, src_valid = 0, stall = 0, clk_en = 1;
   logic snk_ready, src_ready, snk_valid, err_unsup_ff, drop_ff, overrun_ff;
   sia_in_beat_t  src_beat = '0;
   sia_out_beat_t snk_beat, exp_b;
   sia_out_beat_t exp_q[$];
   logic [15:0] rnd = 16'h67c2;
   logic saw_drop = 0, saw_unsup = 0;
   int failures = 0, cmp_count = 0, cycles = 0, i;
   always #4 ref_clk = ~ref_clk;
   sia_adapter u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
      .src_valid(src_valid), .src_beat(src_beat), .src_ready(src_ready),
      .snk_valid(snk_valid), .snk_beat(snk_beat), .snk_ready(snk_ready),
      .err_unsup_ff(err_unsup_ff), .drop_ff(drop_ff),
      .overrun_ff(overrun_ff));
   sia_sink_model u_snk (.ref_clk(ref_clk), .reset_n(reset_n),
      .stall(stall), .snk_ready(snk_ready));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic check(input string name, input logic [63:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic summarize;
      if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   task automatic send;
      rnd = lfsr(rnd);
      src_beat.data = {rnd, 16'h1111, rnd, 16'h2222,
                       rnd, 16'h3333, rnd, 16'h4444};
      src_beat.channel = rnd[3:0];
      src_beat.error = rnd[6:4];
      src_beat.sop = rnd[7];
      src_beat.eop = rnd[8];
      src_valid = rnd[9] && src_ready;
      stall = rnd[10] && rnd[11];
      saw_unsup |= src_valid && rnd[6];
      saw_drop |= src_valid && rnd[3:0] >= SINK_CH_LIMIT;
      if (src_valid && rnd[3:0] < SINK_CH_LIMIT)
         for (int k = 0; k < LANES; k++) begin
            exp_b.data = src_beat.data[IN_DATA_W-1-k*OUT_DATA_W -: OUT_DATA_W];
            exp_b.channel = OUT_CH_W'(rnd[3:0]);
            exp_b.error = {1'b0, rnd[5:4]};
            exp_b.sop = rnd[7] && k == 0;
            exp_b.eop = rnd[8] && k == LANES - 1;
            exp_q.push_back(exp_b);
         end
   endtask : send
   always @(negedge ref_clk) begin
      if (reset_n && snk_valid === 1'b1 && snk_ready === 1'b1) begin
         if (exp_q.size() == 0) check("extra_beat", 1, 0);
         else begin
            check("snk_beat", snk_beat, exp_q[0]);
            void'(exp_q.pop_front());
         end
      end
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         summarize();
      end
   end
   initial begin
      repeat (8) @(negedge ref_clk);
      reset_n = 1;
      repeat (500) begin
         @(negedge ref_clk);
         send();
      end
      src_valid = 0;
      stall = 0;
      for (i = 0; i < 400 && exp_q.size() > 0; i++) @(negedge ref_clk);
      repeat (6) @(negedge ref_clk);
      // frozen clock enable: offered beats must not be taken
      clk_en = 0;
      repeat (4) begin
         @(negedge ref_clk);
         src_beat.channel = 4'h1;
         src_valid = 1;
      end
      @(negedge ref_clk);
      src_valid = 0;
      clk_en = 1;
      repeat (8) @(negedge ref_clk);
      check("freeze_out", snk_valid, 0);
      check("queue_left", exp_q.size(), 0);
      check("drop_ff", drop_ff, saw_drop);
      check("err_unsup_ff", err_unsup_ff, saw_unsup);
      check("overrun_ff", overrun_ff, 0);
      summarize();
   end
endmodule : tb_top
`default_nettype wire
